// File: verilog/fpep_protect.sv
`timescale 1ns/10ps
module fpep_protect (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  // Register port
  input  wire fpep_pkg::fpep_bus_s          bus,
  output logic [fpep_pkg::DATA_W-1:0]       rdata,
  // CPU events
  input  wire fpep_pkg::fpep_cpu_s          cpu,
  // Flash array
  input  wire logic [fpep_pkg::DATA_W-1:0]  flash_rdata,
  output logic [fpep_pkg::DATA_W-1:0]       flash_data,
  output logic [fpep_pkg::NBLK-1:0]         prog_en,
  output logic [fpep_pkg::NBLK-1:0]         erase_en,
  output logic                              verify_en,
  output logic                              err_protect,
  output logic                              irq
);
  import fpep_pkg::*;

  logic [DATA_W-1:0] ctrl_one_reg;
  logic              ferr_reg;
  logic [NBLK-1:0]   ebmask_reg;
  logic [1:0]        irq_stat_reg;
  logic [1:0]        irq_mask_reg;
  fpep_mode_e        mode_reg;
  fpep_mode_e        mode_next;
  logic              active;
  logic              sw_ok;
  logic              err_set;
  logic              refused;

  // An operation is active whenever program or erase is requested.
  assign active = ctrl_one_reg[BIT_PROG] | ctrl_one_reg[BIT_ERASE];
  // Both software enable and a nonzero mask are needed.
  assign sw_ok = ctrl_one_reg[BIT_SWE] && ebmask_reg != '0;
  // Only these three CPU events are malfunctions.
  assign err_set = active &&
    (cpu.flash_read || cpu.exception || cpu.sleep);
  // A refused request is only reported, but a CPU event during it still sets the error.
  assign refused = active && !sw_ok && !ferr_reg;

  // Registers keep contents on error and stay writable; standby clears.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_one_reg <= REG_RST;
      ebmask_reg   <= '0;
    end else if (cpu.standby) begin
      ctrl_one_reg <= REG_RST;
      ebmask_reg   <= '0;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_CTRL_ONE) begin
        ctrl_one_reg <= bus.wdata;
      end else if (bus.addr == ADDR_EBMASK) begin
        ebmask_reg <= bus.wdata[NBLK-1:0];
      end
    end
  end

  // The flag is registered on the clock edge after the event; only reset clears.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ferr_reg <= 1'b0;
    end else if (err_set) begin
      ferr_reg <= 1'b1;
    end
  end

  always_comb begin
    mode_next = FPEP_IDLE;
    if (cpu.standby || err_set) begin
      mode_next = FPEP_IDLE;
    end else if (ctrl_one_reg[BIT_PROG] && sw_ok && !ferr_reg) begin
      mode_next = FPEP_PROG;
    end else if (ctrl_one_reg[BIT_ERASE] && sw_ok && !ferr_reg) begin
      mode_next = FPEP_ERASE;
    end else if (ctrl_one_reg[BIT_PVER] && ctrl_one_reg[BIT_SWE]) begin
      mode_next = FPEP_PVERIFY;
    end else if (ctrl_one_reg[BIT_EVER] && ctrl_one_reg[BIT_SWE]) begin
      mode_next = FPEP_EVERIFY;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= FPEP_IDLE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Abort takes effect in the same cycle as the error event.
  always_comb begin
    prog_en  = '0;
    erase_en = '0;
    case (mode_reg)
      FPEP_PROG: begin
        prog_en = (err_set || ferr_reg) ? '0 : ebmask_reg;
      end
      FPEP_ERASE: begin
        erase_en = (err_set || ferr_reg) ? '0 : ebmask_reg;
      end
      default: begin
      end
    endcase
  end
  assign verify_en   = mode_reg == FPEP_PVERIFY || mode_reg == FPEP_EVERIFY;
  assign err_protect = ferr_reg;

  // Reads during an operation return a fixed pattern, not array data.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_data <= REG_RST;
    end else if (cpu.flash_read) begin
      flash_data <= active ? UNDEF_RD : flash_rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == IRQ_ERR && err_set) || (i == IRQ_REFUSED && refused)) begin
          irq_stat_reg[i] <= 1'b1;
        end else if (bus.wr && bus.addr == ADDR_IRQ_STAT && bus.wdata[i]) begin
          irq_stat_reg[i] <= 1'b0;
        end
      end
      if (bus.wr && bus.addr == ADDR_IRQ_MASK) begin
        irq_mask_reg <= bus.wdata[1:0];
      end
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= REG_RST;
    end else if (bus.rd) begin
      if (bus.addr == ADDR_CTRL_ONE) begin
        rdata <= ctrl_one_reg;
      end else if (bus.addr == ADDR_CTRL_TWO) begin
        rdata <= {ferr_reg, {(DATA_W-1){1'b0}}};
      end else if (bus.addr == ADDR_EBMASK) begin
        rdata <= ebmask_reg;
      end else if (bus.addr == ADDR_IRQ_STAT) begin
        rdata <= {6'h00, irq_stat_reg};
      end else if (bus.addr == ADDR_IRQ_MASK) begin
        rdata <= {6'h00, irq_mask_reg};
      end else if (bus.addr == ADDR_MODE) begin
        rdata <= {5'h00, mode_reg};
      end else begin
        rdata <= REG_RST;
      end
    end else begin
      rdata <= REG_RST;
    end
  end

endmodule // fpep_protect

// File: pkg/fpep_pkg.sv
// Summary of operation
// - Software write enable at zero protects every block from program and erase.
// - Unselected blocks refuse program and erase but still allow verify.
// - An all-zero erase block mask protects every block.
// - Program or erase bit set means an operation is active.
// - Malfunction during an active operation sets the error flag and protection.
// - Error protection aborts the mode at once and keeps register contents.
// - In error protection, rewriting program or erase bits does not restart.
// - In error protection, verify bits still work and enter verify mode.
// - Any flash read during an active operation sets the error flag.
// - Flash read data during an active operation is undefined.
// - Non-reset exception entry during an operation sets the flag before stacking.
// - Sleep during an active operation sets the error flag; standby does not.
// - Only reset clears the error flag and leaves error protection.
// - Registers stay writable in error protection; standby initialises the first control register and the mask.
// - Only the listed conditions set the error flag.
// - Under software protection, program or erase bits do not enter the mode.
// - Reset clears all three registers; standby entry clears the first control register and the mask; both protect.
package fpep_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NBLK   = 8;

  localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_EBMASK   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_MODE     = 4'h5;

  // Bit positions within the first control register.
  localparam int unsigned BIT_PROG = 0;
  localparam int unsigned BIT_ERASE = 1;
  localparam int unsigned BIT_PVER = 2;
  localparam int unsigned BIT_EVER = 3;
  localparam int unsigned BIT_SWE  = 6;
  // Bit position of the error flag within the second control register.
  localparam int unsigned BIT_FERR = 7;

  // Interrupt status bits.
  localparam int unsigned IRQ_ERR = 0;
  localparam int unsigned IRQ_REFUSED = 1;

  localparam logic [DATA_W-1:0] REG_RST  = 8'h00;
  localparam logic [DATA_W-1:0] UNDEF_RD = 8'hFF;

  typedef enum logic [2:0] {
    FPEP_IDLE    = 3'b000,
    FPEP_PROG    = 3'b001,
    FPEP_ERASE   = 3'b011,
    FPEP_PVERIFY = 3'b010,
    FPEP_EVERIFY = 3'b110
  } fpep_mode_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fpep_bus_s;

  typedef struct packed {
    logic flash_read;
    logic exception;
    logic sleep;
    logic standby;
  } fpep_cpu_s;
endpackage

// File: sim/fpep_cpu_model.sv
`timescale 1ns/10ps
module fpep_cpu_model (
  // Clock
  input  wire logic                   clk,
  // Bench commands, one bit for each event kind
  input  wire logic [3:0]             cmd,
  // CPU and array side
  output fpep_pkg::fpep_cpu_s         cpu,
  output logic [fpep_pkg::DATA_W-1:0] flash_rdata
);
  import fpep_pkg::*;
  initial begin
    cpu = '0;
    flash_rdata = 8'h5A;
  end
  // The array never holds its lines, so its data moves every cycle.
  always @(posedge clk) begin
    cpu <= {cmd[0], cmd[1], cmd[2], cmd[3]};
    flash_rdata <= flash_rdata + 8'h01;
  end
endmodule // fpep_cpu_model

// File: sim/fpep_protect_monitor.sv
`timescale 1ns/10ps
module fpep_protect_monitor (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst_b,
  // Watched ports
  input wire fpep_pkg::fpep_bus_s        bus,
  input wire fpep_pkg::fpep_cpu_s        cpu,
  input wire logic [fpep_pkg::DATA_W-1:0] flash_data,
  input wire logic [fpep_pkg::NBLK-1:0]  prog_en,
  input wire logic [fpep_pkg::NBLK-1:0]  erase_en,
  input wire logic                       verify_en,
  input wire logic                       err_protect
);
  import fpep_pkg::*;
  wire ev = cpu.flash_read | cpu.exception | cpu.sleep;
  wire pe = (|prog_en) | (|erase_en);
  // Enables lag the control register, so two quiet cycles prove activity.
  wire quiet = !bus.wr & !cpu.standby;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence act_ev;
    quiet ##1 (quiet && pe) ##1 ev;
  endsequence
  a_err_sticky: assert property (err_protect |=> err_protect)
    else $error("error flag dropped");
  a_err_cause: assert property ($rose(err_protect) |-> $past(ev))
    else $error("error flag without cause");
  a_no_restart: assert property (err_protect |-> !pe)
    else $error("enable while in error");
  a_abort_now: assert property (ev |-> !pe)
    else $error("enable not dropped at once");
  a_err_event: assert property (act_ev |=> err_protect)
    else $error("error flag not set");
  a_read_undef: assert property (act_ev ##0 cpu.flash_read |=>
    flash_data == UNDEF_RD) else $error("flash data not undefined");
  a_stby_clear: assert property (cpu.standby |=> !pe && !verify_en)
    else $error("standby left a mode");
  a_verify_excl: assert property (verify_en |-> !pe)
    else $error("verify beside program or erase");
  c_error: cover property ($rose(err_protect));
  c_prog: cover property (|prog_en);
  c_verify: cover property (verify_en);
endmodule // fpep_protect_monitor
bind fpep_protect fpep_protect_monitor mon_u (.clk(clk), .rst_b(rst_b),
  .bus(bus), .cpu(cpu), .flash_data(flash_data), .prog_en(prog_en),
  .erase_en(erase_en), .verify_en(verify_en), .err_protect(err_protect));

// File: sim/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  import fpep_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  fpep_bus_s bus = '0;
  fpep_cpu_s cpu;
  logic [3:0] cmd = 4'h0;
  logic [DATA_W-1:0] flash_rdata, rdata, flash_data;
  logic [NBLK-1:0] prog_en, erase_en;
  logic verify_en, err_protect, irq, i0;
  int err_count = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  fpep_cpu_model cpu_u (.clk(clk), .cmd(cmd), .cpu(cpu),
    .flash_rdata(flash_rdata));
  fpep_protect dut_u (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .cpu(cpu), .flash_rdata(flash_rdata), .flash_data(flash_data),
    .prog_en(prog_en), .erase_en(erase_en), .verify_en(verify_en),
    .err_protect(err_protect), .irq(irq));
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk) bus <= {1'b1, 1'b0, a, d};
    @(posedge clk) bus <= '0;
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk) bus <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk) bus <= '0;
    #1 `CHK("rdata", e, rdata)
  endtask
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task ev(input int k);
    @(posedge clk) cmd <= 4'h1 << k;
    @(posedge clk) cmd <= 4'h0;
    #1 `CHK("enables", 8'h00, prog_en | erase_en)
    @(posedge clk) #1 `CHK("err", 1'b1, err_protect)
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000 err_count++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_EBMASK, REG_RST);
    wr(ADDR_EBMASK, 8'h05);
    wr(ADDR_CTRL_ONE, 8'h01);
    settle;
    `CHK("prog_en", 8'h00, prog_en)
    rd(ADDR_IRQ_STAT, 8'h02);
    wr(ADDR_EBMASK, 8'h00);
    wr(ADDR_CTRL_ONE, 8'h41);
    settle;
    `CHK("prog_en", 8'h00, prog_en)
    for (int k = 0; k < 3; k++) begin
      rst_b <= 1'b0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      wr(ADDR_EBMASK, 8'h05);
      wr(ADDR_CTRL_ONE, 8'h42);
      settle;
      `CHK("erase_en", 8'h05, erase_en)
      wr(ADDR_CTRL_ONE, 8'h41);
      settle;
      `CHK("prog_en", 8'h05, prog_en)
      ev(k);
      if (k == 0) `CHK("flash_data", UNDEF_RD, flash_data)
      rd(ADDR_CTRL_ONE, 8'h41);
      rd(ADDR_EBMASK, 8'h05);
      wr(ADDR_CTRL_TWO, 8'h00);
      rd(ADDR_CTRL_TWO, 8'h80);
      wr(ADDR_CTRL_ONE, 8'h42);
      settle;
      `CHK("enables", 8'h00, prog_en | erase_en)
      wr(ADDR_CTRL_ONE, 8'h48);
      settle;
      `CHK("verify_en", 1'b1, verify_en)
      wr(ADDR_IRQ_MASK, 8'h00);
      #1 i0 = irq;
      wr(ADDR_IRQ_MASK, 8'hFF);
      #1 `CHK("irq", 1'b1, i0 ^ irq)
      wr(ADDR_IRQ_STAT, 8'h03);
      rd(ADDR_IRQ_STAT, 8'h00);
      wr(ADDR_EBMASK, 8'h03);
      rd(ADDR_EBMASK, 8'h03);
      ev(3);
      rd(ADDR_EBMASK, 8'h00);
      rd(ADDR_CTRL_ONE, 8'h00);
    end
    conclude;
  end
endmodule // tb
